// File: logic/modem_ctrl_params.svh
/*
  Constants of the modem command and data mode controller.
  Assumes a 200 MHz controller clock.
*/
`ifndef MODEM_CTRL_PARAMS_SVH
`define MODEM_CTRL_PARAMS_SVH
`define CLK_HZ 200000000
`define HOST_BAUD 19200
`define BIT_CYC (`CLK_HZ / `HOST_BAUD)
`define POLL_MS 20
`define POLL_CYC (`CLK_HZ / 1000 * `POLL_MS)
`define A_RING 4'h0
`define A_GAIN 4'h4
`define A_STAT 4'h8
`define RING_RST 8'h00
`define GAIN_RST 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CH_A 8'h41
`define CH_T 8'h54
`define CH_D 8'h44
`define CH_H 8'h48
`define CH_O 8'h4F
`define CH_CR 8'h0D
`define CH_PLUS 8'h2B
`define CTS_LIMIT 3'h2
`endif

// File: logic/modem_ctrl_pkg.sv
/*
  Types of the modem command and data mode controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package modem_ctrl_pkg;
  // Gray along command, configure, dial, tone, negotiate, data, on-line.
  typedef enum logic [2:0] {
    M_CMD = 3'h0, M_CFG = 3'h1, M_DIAL = 3'h3, M_CPT = 3'h2,
    M_NEG = 3'h6, M_DATA = 3'h7, M_ONL = 3'h5
  } mode_t;
  typedef enum logic [1:0] {
    P_A = 2'h0, P_T = 2'h1, P_CMD = 2'h3, P_CR = 2'h2
  } parse_t;
  typedef enum logic [1:0] {
    STEP_DIAL = 2'h0, STEP_CPT = 2'h1, STEP_NEG = 2'h3
  } step_t;
  // Settings captured for the line device when a call starts.
  typedef struct packed {
    logic [7:0] tx_gain;
    logic answer;
  } dev_cfg_t;
endpackage

// File: logic/modem_command_data_mode_ctrl.sv
/*
  Modem controller: host serial link, command parser, call sequencing,
  ring polling, data forwarding with escape detection, AXI4-Lite slave.
  Assumes the line device logic runs on the same clock and answers its
  step, status and data handshakes synchronously.
*/
`timescale 1ns/1ps
`default_nettype none
`include "modem_ctrl_params.svh"
module modem_command_data_mode_ctrl
  import modem_ctrl_pkg::*;
#(
  parameter int BIT_CYCLES = `BIT_CYC,
  parameter int POLL_CYCLES = `POLL_CYC
)(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic host_rxd,
  output logic host_txd,
  input wire logic host_rts,
  output logic host_cts,
  output logic line_tx_valid,
  input wire logic line_tx_ready,
  output logic [7:0] line_tx_data,
  input wire logic line_rx_valid,
  output logic line_rx_ready,
  input wire logic [7:0] line_rx_data,
  output logic step_go,
  output step_t step_sel,
  output logic step_abort,
  input wire logic step_done,
  input wire logic step_fail,
  output logic cfg_wr,
  output dev_cfg_t cfg,
  output logic stat_rd,
  input wire logic stat_ring,
  output logic off_hook,
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  localparam logic [15:0] BIT_W = 16'(BIT_CYCLES);
  localparam logic [22:0] POLL_W = 23'(POLL_CYCLES);
  logic [1:0] rxd_s_r, rts_s_r;
  logic rx_busy_r, rx_busy_nxt, tx_busy_r, tx_busy_nxt;
  logic [15:0] rx_cnt_r, rx_cnt_nxt, tx_cnt_r, tx_cnt_nxt;
  logic [3:0] rx_bit_r, rx_bit_nxt, tx_bit_r, tx_bit_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt;
  logic [9:0] tx_sh_r, tx_sh_nxt;
  logic [7:0] fifo_r [4];
  logic [1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic push, pop, cts_r;
  logic [7:0] ch;
  mode_t mode_r, mode_nxt;
  parse_t parse_r, parse_nxt;
  logic [7:0] cmd_r, cmd_nxt, ring_set_r, gain_r, rings_r, rings_nxt;
  logic [1:0] plus_r, plus_nxt;
  logic [22:0] poll_r, poll_nxt;
  logic ring_seen_r, ring_seen_nxt, hook_r, hook_nxt, exec;
  logic go_r, go_nxt, abort_r, abort_nxt, wr_r, wr_nxt, rd_r, rd_nxt;
  step_t sel_r, sel_nxt;
  dev_cfg_t cfg_r, cfg_nxt;
  logic aw_r, w_r, bv_r, rv_r;
  logic [3:0] awa_r;
  logic [31:0] wd_r, rdat_r;
  logic [1:0] bresp_r, rresp_r;

  // Pins from the host are foreign to this clock; two stages first.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rxd_s_r <= 2'h3;
      rts_s_r <= 2'h0;
    end
    else
    begin
      rxd_s_r <= {rxd_s_r[0], host_rxd};
      rts_s_r <= {rts_s_r[0], host_rts};
    end
  end

  // Host link, 8N1: receiver samples mid-bit, transmitter only in data mode.
  assign ch = fifo_r[rp_r];
  assign pop = (cnt_r != 3'h0) && (mode_r != M_DATA || line_tx_ready);
  assign line_tx_valid = (mode_r == M_DATA) && (cnt_r != 3'h0);
  assign line_tx_data = ch;
  assign line_rx_ready = (mode_r == M_DATA) && !tx_busy_r;
  always_comb
  begin
    rx_busy_nxt = rx_busy_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_bit_nxt = rx_bit_r;
    rx_sh_nxt = rx_sh_r;
    push = 1'b0;
    tx_busy_nxt = tx_busy_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_bit_nxt = tx_bit_r;
    tx_sh_nxt = tx_sh_r;
    if (!rx_busy_r)
    begin
      if (!rxd_s_r[1])
      begin
        rx_busy_nxt = 1'b1;
        rx_cnt_nxt = {1'b0, BIT_W[15:1]};
        rx_bit_nxt = 4'h0;
      end
    end
    else if (rx_cnt_r != 16'h0)
      rx_cnt_nxt = rx_cnt_r - 16'h1;
    else
    begin
      rx_cnt_nxt = BIT_W - 16'h1;
      rx_bit_nxt = rx_bit_r + 4'h1;
      if (rx_bit_r == 4'h0 && rxd_s_r[1])
        rx_busy_nxt = 1'b0; // A glitch, not a start bit.
      else if (rx_bit_r == 4'h9)
      begin
        rx_busy_nxt = 1'b0;
        push = rxd_s_r[1];
      end
      else if (rx_bit_r != 4'h0)
        rx_sh_nxt = {rxd_s_r[1], rx_sh_r[7:1]};
    end
    if (!tx_busy_r)
    begin
      if (line_rx_valid && line_rx_ready)
      begin
        tx_busy_nxt = 1'b1;
        tx_sh_nxt = {1'b1, line_rx_data, 1'b0};
        tx_cnt_nxt = BIT_W - 16'h1;
        tx_bit_nxt = 4'h0;
      end
    end
    else if (tx_cnt_r != 16'h0)
      tx_cnt_nxt = tx_cnt_r - 16'h1;
    else
    begin
      tx_cnt_nxt = BIT_W - 16'h1;
      tx_sh_nxt = {1'b1, tx_sh_r[9:1]};
      tx_bit_nxt = tx_bit_r + 4'h1;
      tx_busy_nxt = (tx_bit_r != 4'h9);
    end
    wp_nxt = wp_r + 2'(push && cnt_r != 3'h4);
    rp_nxt = rp_r + 2'(pop);
    cnt_nxt = cnt_r + 3'(push && cnt_r != 3'h4) - 3'(pop);
  end

  // Clear-to-send leaves room for a character already in flight.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rx_busy_r <= 1'b0;
      rx_cnt_r <= 16'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 8'h00;
      tx_busy_r <= 1'b0;
      tx_cnt_r <= 16'h0;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 10'h3FF;
      wp_r <= 2'h0;
      rp_r <= 2'h0;
      cnt_r <= 3'h0;
      cts_r <= 1'b0;
    end
    else
    begin
      rx_busy_r <= rx_busy_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_sh_r <= rx_sh_nxt;
      tx_busy_r <= tx_busy_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_sh_r <= tx_sh_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      cts_r <= rts_s_r[1] && (cnt_nxt < `CTS_LIMIT);
    end
  end

  // The array has no reset; it is only read below the count.
  always_ff @(posedge clock)
  begin
    if (push && cnt_r != 3'h4)
      fifo_r[wp_r] <= rx_sh_r;
  end

  assign host_txd = tx_sh_r[0];
  assign host_cts = cts_r;

  // Command parser and call sequencing.
  always_comb
  begin
    mode_nxt = mode_r;
    parse_nxt = parse_r;
    cmd_nxt = cmd_r;
    plus_nxt = plus_r;
    hook_nxt = hook_r;
    cfg_nxt = cfg_r;
    sel_nxt = sel_r;
    go_nxt = 1'b0;
    abort_nxt = 1'b0;
    wr_nxt = 1'b0;
    rd_nxt = 1'b0;
    exec = 1'b0;
    rings_nxt = rings_r;
    ring_seen_nxt = ring_seen_r;
    poll_nxt = poll_r;
    if (pop && (mode_r == M_CMD || mode_r == M_ONL))
    begin
      case (parse_r)
        P_A: parse_nxt = (ch == `CH_A) ? P_T : P_A;
        P_T: parse_nxt = (ch == `CH_T) ? P_CMD : P_A;
        P_CMD:
        begin
          cmd_nxt = ch;
          parse_nxt = P_CR;
        end
        default:
        begin
          exec = (ch == `CH_CR);
          parse_nxt = exec ? P_A : P_CR;
        end
      endcase
    end
    if (mode_r != M_CMD)
    begin
      rings_nxt = 8'h00;
      ring_seen_nxt = 1'b0;
      poll_nxt = POLL_W - 23'h1;
    end
    else if (ring_set_r != 8'h00)
    begin
      poll_nxt = (poll_r == 23'h0) ? POLL_W - 23'h1 : poll_r - 23'h1;
      rd_nxt = (poll_r == 23'h0);
    end
    if (rd_r)
    begin
      ring_seen_nxt = stat_ring;
      if (stat_ring && !ring_seen_r)
        rings_nxt = rings_r + 8'h01;
    end
    case (mode_r)
      M_CMD:
      begin
        if (exec && (cmd_r == `CH_D || cmd_r == `CH_A))
        begin
          mode_nxt = M_CFG;
          cfg_nxt = '{tx_gain: gain_r, answer: cmd_r == `CH_A};
        end
        else if (exec && cmd_r == `CH_H)
          hook_nxt = 1'b0;
        else if (rd_r && stat_ring && !ring_seen_r
                 && rings_r + 8'h01 == ring_set_r)
        begin
          mode_nxt = M_CFG;
          cfg_nxt = '{tx_gain: gain_r, answer: 1'b1};
        end
      end
      M_CFG:
      begin
        wr_nxt = 1'b1;
        go_nxt = 1'b1;
        sel_nxt = STEP_DIAL;
        hook_nxt = 1'b1;
        mode_nxt = M_DIAL;
      end
      M_DIAL, M_CPT, M_NEG:
      begin
        if (mode_r == M_NEG && pop)
        begin
          abort_nxt = 1'b1;
          hook_nxt = 1'b0;
          mode_nxt = M_CMD;
        end
        else if (step_done && step_fail)
        begin
          hook_nxt = 1'b0;
          mode_nxt = M_CMD;
        end
        else if (step_done)
        begin
          go_nxt = (mode_r != M_NEG);
          sel_nxt = (mode_r == M_DIAL) ? STEP_CPT : STEP_NEG;
          mode_nxt = (mode_r == M_DIAL) ? M_CPT
                   : (mode_r == M_CPT) ? M_NEG : M_DATA;
          plus_nxt = 2'h0;
        end
      end
      M_DATA:
      begin
        if (pop)
        begin
          plus_nxt = (ch == `CH_PLUS) ? plus_r + 2'h1 : 2'h0;
          if (ch == `CH_PLUS && plus_r == 2'h2)
          begin
            mode_nxt = M_ONL;
            plus_nxt = 2'h0;
          end
        end
      end
      M_ONL:
      begin
        if (exec && cmd_r == `CH_H)
        begin
          hook_nxt = 1'b0;
          mode_nxt = M_CMD;
        end
        else if (exec && cmd_r == `CH_O)
          mode_nxt = M_DATA;
      end
      default: mode_nxt = M_CMD;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      mode_r <= M_CMD;
      parse_r <= P_A;
      cmd_r <= 8'h00;
      plus_r <= 2'h0;
      hook_r <= 1'b0;
      cfg_r <= '0;
      sel_r <= STEP_DIAL;
      go_r <= 1'b0;
      abort_r <= 1'b0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      rings_r <= 8'h00;
      ring_seen_r <= 1'b0;
      poll_r <= 23'h0;
    end
    else
    begin
      mode_r <= mode_nxt;
      parse_r <= parse_nxt;
      cmd_r <= cmd_nxt;
      plus_r <= plus_nxt;
      hook_r <= hook_nxt;
      cfg_r <= cfg_nxt;
      sel_r <= sel_nxt;
      go_r <= go_nxt;
      abort_r <= abort_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      rings_r <= rings_nxt;
      ring_seen_r <= ring_seen_nxt;
      poll_r <= poll_nxt;
    end
  end

  assign step_go = go_r;
  assign step_sel = sel_r;
  assign step_abort = abort_r;
  assign cfg_wr = wr_r;
  assign cfg = cfg_r;
  assign stat_rd = rd_r;
  assign off_hook = hook_r;

  // AXI4-Lite slave; address and data are latched in either order.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awa_r <= 4'h0;
      wd_r <= 32'h0;
      bv_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      rv_r <= 1'b0;
      rdat_r <= 32'h0;
      rresp_r <= `RESP_OKAY;
      ring_set_r <= `RING_RST;
      gain_r <= `GAIN_RST;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_r <= 1'b1;
        awa_r <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        w_r <= 1'b1;
        // A disabled low lane leaves the upper bits set so nothing is stored.
        wd_r <= (s_wstrb[0]) ? s_wdata : 32'hFFFFFFFF;
      end
      if (aw_r && w_r && !bv_r)
      begin
        aw_r <= 1'b0;
        w_r <= 1'b0;
        bv_r <= 1'b1;
        bresp_r <= (awa_r == `A_RING || awa_r == `A_GAIN)
                   ? `RESP_OKAY : `RESP_SLVERR;
        if (awa_r == `A_RING && wd_r[31:8] == 24'h0)
          ring_set_r <= wd_r[7:0];
        if (awa_r == `A_GAIN && wd_r[31:8] == 24'h0)
          gain_r <= wd_r[7:0];
      end
      else if (bv_r && s_bready)
        bv_r <= 1'b0;
      if (s_arvalid && s_arready)
      begin
        rv_r <= 1'b1;
        rresp_r <= (s_araddr == `A_STAT || s_araddr == `A_RING
                    || s_araddr == `A_GAIN) ? `RESP_OKAY : `RESP_SLVERR;
        rdat_r <= (s_araddr == `A_RING) ? {24'h0, ring_set_r}
                : (s_araddr == `A_GAIN) ? {24'h0, gain_r}
                : (s_araddr == `A_STAT)
                  ? {16'h0, rings_r, 3'h0, hook_r, 1'b0, mode_r} : 32'h0;
      end
      else if (rv_r && s_rready)
        rv_r <= 1'b0;
    end
  end

  assign s_awready = !aw_r;
  assign s_wready = !w_r;
  assign s_bvalid = bv_r;
  assign s_bresp = bresp_r;
  assign s_arready = !rv_r;
  assign s_rvalid = rv_r;
  assign s_rdata = rdat_r;
  assign s_rresp = rresp_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_start; $past(sys_rst) |-> mode_r == M_CMD; endproperty
  a_start: assert property (p_start) else $error("not in command mode");
  property p_exec; mode_r == M_CMD && exec && cmd_r == `CH_D |=> mode_r == M_CFG ##1 mode_r == M_DIAL && step_go; endproperty
  a_exec: assert property (p_exec) else $error("dial not run");
  property p_order; mode_r == M_DIAL && step_done && !step_fail |=> mode_r == M_CPT && step_go && step_sel == STEP_CPT; endproperty
  a_order: assert property (p_order) else $error("tone step skipped");
  property p_cfg; $rose(off_hook) |-> $past(mode_r) == M_CFG && cfg_wr; endproperty
  a_cfg: assert property (p_cfg) else $error("no config write");
  property p_abort; mode_r == M_NEG && pop |=> step_abort && !off_hook && mode_r == M_CMD; endproperty
  a_abort: assert property (p_abort) else $error("negotiation not aborted");
  property p_poll; stat_rd |-> ring_set_r != 8'h00 ##1 !stat_rd [*8]; endproperty
  a_poll: assert property (p_poll) else $error("poll misplaced");
  property p_data; mode_r == M_NEG && step_done && !step_fail && !pop |=> mode_r == M_DATA; endproperty
  a_data: assert property (p_data) else $error("data mode not entered");
  property p_hold; line_tx_valid && !line_tx_ready |=> line_tx_valid && $stable(line_tx_data); endproperty
  a_hold: assert property (p_hold) else $error("line byte lost");
  property p_esc; mode_r == M_DATA && pop && ch == `CH_PLUS && plus_r == 2'h2 |=> mode_r == M_ONL && off_hook; endproperty
  a_esc: assert property (p_esc) else $error("escape missed");
  c_call: cover property (mode_r == M_NEG ##1 mode_r == M_DATA);
  c_esc: cover property (mode_r == M_DATA ##1 mode_r == M_ONL);
  c_ring: cover property (mode_r == M_CMD && rd_r ##1 mode_r == M_CFG);
endmodule
`default_nettype wire

// File: dv/host_term.sv
/*
  Host terminal model: 8N1 serial sender and receiver with RTS/CTS.
  Assumes it shares the controller clock and bit period in clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module host_term #(
  parameter int BIT_CYCLES = 16
)(
  input wire logic clock,
  output logic txd,
  input wire logic rxd,
  output logic rts,
  input wire logic cts,
  output logic rx_stb,
  output logic [7:0] rx_byte
);
  // Count of sends that gave up waiting for clear-to-send.
  int lost = 0;

  // The line idles high and request-to-send starts up.
  initial
  begin
    txd = 1'b1;
    rts = 1'b1;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
  end

  // Sends one frame LSB first, waiting up to 20000 cycles for clear-to-send and then sending anyway.
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    int n;
    fr = {1'b1, b, 1'b0};
    for (n = 0; n < 20000 && cts !== 1'b1; n++)
      @(posedge clock);
    if (cts !== 1'b1)
      lost++; // The bench counts this as a mismatch at the end.
    for (n = 0; n < 10; n++)
    begin
      txd <= fr[n];
      repeat (BIT_CYCLES) @(posedge clock);
    end
  endtask

  // Lets the bench drop request-to-send to see clear-to-send follow.
  task automatic hold_off(input logic v);
    rts <= v;
  endtask

  // Samples mid-bit; a bad stop bit inverts the byte so framing faults
  // surface as data mismatches instead of passing silently.
  initial
  begin
    logic [7:0] sh;
    forever
    begin
      @(negedge rxd);
      repeat (BIT_CYCLES / 2) @(posedge clock);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYCLES) @(posedge clock);
        sh[i] = rxd;
      end
      repeat (BIT_CYCLES) @(posedge clock);
      rx_byte <= rxd ? sh : ~sh;
      rx_stb <= 1'b1;
      @(posedge clock);
      rx_stb <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: dv/modem_command_data_mode_ctrl_tb_top.sv
/*
  Self-checking bench of the modem controller: AXI4-Lite master, host
  model, line device and step responders, and an event scoreboard.
  Assumes the controller package and a 5 ns clock.
*/
`timescale 1ns/1ps
`default_nettype none
module modem_command_data_mode_ctrl_tb_top;
  import modem_ctrl_pkg::*;
  localparam int BITC = 16;
  localparam int POLL = 20;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  wire logic host_rxd, host_txd, host_rts, host_cts, stat_ring;
  logic line_tx_valid, line_rx_ready, step_go, step_abort, cfg_wr, stat_rd;
  logic off_hook, s_awready, s_wready, s_bvalid, s_arready, s_rvalid, rx_stb;
  logic [7:0] line_tx_data, rx_byte;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  step_t step_sel;
  dev_cfg_t cfg;
  logic line_tx_ready = 1'b1, line_rx_valid = 1'b0, step_done = 1'b0;
  logic step_fail = 1'b0, fail_cpt = 1'b0;
  logic [7:0] line_rx_data = 8'h00, lfsr = 8'h61, b;
  logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'h0;
  logic [3:0] step_cnt = 4'h0, poll_n = 4'h0;
  logic [3:0] strb = 4'hF;
  logic [31:0] s_wdata = 32'h0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0, hold_neg = 1'b0, ring_on = 1'b0;
  logic [15:0] q[$];
  int cyc = 0, last_poll = 0, err_count = 0, total_checks = 0;

  modem_command_data_mode_ctrl #(.BIT_CYCLES(BITC), .POLL_CYCLES(POLL))
  i_modem_command_data_mode_ctrl (
    .clock(clock), .sys_rst(sys_rst), .host_rxd(host_rxd),
    .host_txd(host_txd), .host_rts(host_rts), .host_cts(host_cts),
    .line_tx_valid(line_tx_valid), .line_tx_ready(line_tx_ready),
    .line_tx_data(line_tx_data), .line_rx_valid(line_rx_valid),
    .line_rx_ready(line_rx_ready), .line_rx_data(line_rx_data),
    .step_go(step_go), .step_sel(step_sel), .step_abort(step_abort),
    .step_done(step_done), .step_fail(step_fail), .cfg_wr(cfg_wr), .cfg(cfg),
    .stat_rd(stat_rd), .stat_ring(stat_ring), .off_hook(off_hook),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready));

  host_term #(.BIT_CYCLES(BITC)) i_host_term (
    .clock(clock), .txd(host_rxd), .rxd(host_txd), .rts(host_rts),
    .cts(host_cts), .rx_stb(rx_stb), .rx_byte(rx_byte));

  // Ringing shows on every second poll, so each ring cycle takes two polls.
  assign stat_ring = ring_on & poll_n[0];

  // Clock of 5 ns period.
  initial
  begin
    forever #2.5 clock = ~clock;
  end

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic stall();
    check("wait bound", 16'h0001, 16'h0000);
    close_out();
  endtask

  task automatic see(input logic [15:0] v);
    if (q.size() == 0)
      check("event", v, 16'hFFFF);
    else
      check("event", v, q.pop_front());
  endtask

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr | 8'h80;
  endfunction

  // Scoreboard: results at one edge are taken in a fixed order.
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cfg_wr)
      see({7'h08, cfg});
    if (step_go)
      see({4'h2, 10'h000, step_sel});
    if (step_abort)
      see(16'h3000);
    if (line_tx_valid && line_tx_ready)
      see({8'h40, line_tx_data});
    if (rx_stb)
      see({8'h50, rx_byte});
    if (s_rvalid && s_rready)
      see({4'h6, s_rresp, s_rdata[9:0]});
    if (s_bvalid && s_bready)
      see({12'h700, 2'h0, s_bresp});
    if (stat_rd)
    begin
      if (last_poll != 0)
        check("poll gap", 16'(cyc - last_poll), 16'(POLL));
      last_poll <= cyc;
      poll_n <= poll_n + 4'h1;
    end
  end

  // Line device steps finish a few cycles after they start; negotiation
  // can be held open so that a host key can abort it, and the tone step
  // can be made to fail.
  always @(posedge clock)
  begin
    step_done <= (step_cnt == 4'h1);
    step_fail <= (step_cnt == 4'h1) && fail_cpt && step_sel == STEP_CPT;
    if (step_go && !(hold_neg && step_sel == STEP_NEG))
      step_cnt <= 4'h5;
    else if (step_cnt != 4'h0)
      step_cnt <= step_cnt - 4'h1;
  end

  // One AXI4-Lite transfer; the expected response word is noted first.
  task automatic axi(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [15:0] e);
    logic done;
    int n;
    q.push_back(e);
    @(posedge clock);
    if (wr)
    begin
      s_awaddr <= a;
      s_wdata <= d;
      s_wstrb <= strb;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
    end
    else
    begin
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
    end
    done = 1'b0;
    for (n = 0; n < 100 && !done; n++)
    begin
      @(posedge clock);
      if (s_awready === 1'b1)
        s_awvalid <= 1'b0;
      if (s_wready === 1'b1)
        s_wvalid <= 1'b0;
      if (s_arready === 1'b1)
        s_arvalid <= 1'b0;
      if ((s_bvalid && s_bready) === 1'b1 || (s_rvalid && s_rready) === 1'b1)
      begin
        s_bready <= 1'b0;
        s_rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
      stall();
  endtask

  task automatic drain();
    for (int n = 0; n < 4000 && q.size() != 0; n++)
      @(posedge clock);
    if (q.size() != 0)
      stall();
  endtask

  // A line byte is held until taken, then the data bus shows garbage.
  task automatic line_send(input logic [7:0] v);
    logic done;
    q.push_back({8'h50, v});
    @(posedge clock);
    line_rx_data <= v;
    line_rx_valid <= 1'b1;
    done = 1'b0;
    for (int n = 0; n < 2000 && !done; n++)
    begin
      @(posedge clock);
      done = (line_rx_ready === 1'b1);
    end
    line_rx_valid <= 1'b0;
    line_rx_data <= ~v;
    if (!done)
      stall();
    drain();
  endtask

  task automatic say(input string s);
    for (int i = 0; i < s.len(); i++)
      i_host_term.send(8'(s[i]));
  endtask

  task automatic call_notes(input logic [15:0] c);
    q.push_back(c);
    q.push_back(16'h2000);
    q.push_back(16'h2001);
    q.push_back(16'h2003);
  endtask

  // Main sequence.
  initial
  begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    axi(1'b0, 4'h8, 32'h0, 16'h6000);
    // Clear-to-send follows request-to-send through the synchroniser.
    i_host_term.hold_off(1'b0);
    repeat (4) @(posedge clock);
    check("clear to send", {15'h0, host_cts}, 16'h0000);
    i_host_term.hold_off(1'b1);
    repeat (4) @(posedge clock);
    check("clear to send", {15'h0, host_cts}, 16'h0001);
    axi(1'b1, 4'h4, 32'h5A, 16'h7000);
    axi(1'b0, 4'h4, 32'h0, 16'h605A);
    // A write with its low lane disabled must leave the setting alone.
    strb <= 4'h0;
    axi(1'b1, 4'h4, 32'h77, 16'h7000);
    strb <= 4'hF;
    axi(1'b0, 4'h4, 32'h0, 16'h605A);
    axi(1'b1, 4'hC, 32'h1, 16'h7002);
    axi(1'b0, 4'hC, 32'h0, 16'h6800);
    call_notes(16'h10B4);
    say("ATD\r");
    drain();
    line_send(rnd());
    axi(1'b0, 4'h8, 32'h0, 16'h6017);
    b = rnd();
    q.push_back({8'h40, b});
    i_host_term.send(b);
    drain();
    // Stalled line: two bytes fill the limit, the third must wait.
    line_tx_ready <= 1'b0;
    repeat (3) q.push_back({8'h40, rnd()});
    i_host_term.send(q[q.size() - 3][7:0]);
    i_host_term.send(q[q.size() - 2][7:0]);
    check("clear to send", {15'h0, host_cts}, 16'h0000);
    fork
      i_host_term.send(q[q.size() - 1][7:0]);
    join_none
    line_tx_ready <= 1'b1;
    drain();
    wait fork;
    repeat (3) q.push_back(16'h402B);
    say("+++");
    drain();
    axi(1'b0, 4'h8, 32'h0, 16'h6015);
    axi(1'b1, 4'h4, 32'h33, 16'h7000);
    say("ATO\r");
    line_send(rnd());
    repeat (3) q.push_back(16'h402B);
    say("+++");
    drain();
    say("ATH0\r");
    axi(1'b0, 4'h8, 32'h0, 16'h6000);
    // An answer whose tone step fails drops back on-hook to command mode.
    fail_cpt <= 1'b1;
    q.push_back(16'h1067);
    q.push_back(16'h2000);
    q.push_back(16'h2001);
    say("ATA\r");
    drain();
    repeat (8) @(posedge clock);
    fail_cpt <= 1'b0;
    axi(1'b0, 4'h8, 32'h0, 16'h6000);
    hold_neg <= 1'b1;
    call_notes(16'h1066);
    say("ATD\r");
    drain();
    q.push_back(16'h3000);
    say("x");
    drain();
    hold_neg <= 1'b0;
    axi(1'b0, 4'h8, 32'h0, 16'h6000);
    ring_on <= 1'b1;
    axi(1'b1, 4'h0, 32'h2, 16'h7000);
    call_notes(16'h1067);
    drain();
    line_send(rnd());
    axi(1'b0, 4'h8, 32'h0, 16'h6017);
    check("cts waits", 16'(i_host_term.lost), 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
